// *** rtl/dspwm_defines.vh ***
/*
 * Constants for the dual-slope frequency correct pwm block.
 * Assumes inclusion by bare name from rtl files.
 */
`ifndef DSPWM_DEFINES_VH
`define DSPWM_DEFINES_VH
// ==========================================
// waveform modes
`define DSPWM_MODE_CAPTOP 4'h8
`define DSPWM_MODE_CMPATOP 4'h9
`define DSPWM_MODE_PCCMPATOP 4'hb
// ==========================================
// output actions
`define DSPWM_ACT_OFF 2'h0
`define DSPWM_ACT_TOGGLE 2'h1
`define DSPWM_ACT_NONINV 2'h2
`define DSPWM_ACT_INV 2'h3
// ==========================================
// counter values, reset values and sizes
`define DSPWM_BOTTOM 16'h0000
`define DSPWM_MIN_TOP 16'h0003
`define DSPWM_RST_CMP 16'h0000
`define DSPWM_RST_TOP 16'hffff
`define DSPWM_NUM_CH 2
`define DSPWM_WIDTH 16
`endif

// *** rtl/dspwm_channel.v ***
/*
 * One compare channel: double buffered compare value, match flag and
 * waveform output with pin enable.
 * Assumes tick is a one-cycle enable in the core_clk domain.
 */
`timescale 1ns/10ps
`default_nettype none
`include "dspwm_defines.vh"
module dspwm_channel #(
	parameter WIDTH = `DSPWM_WIDTH,
	parameter IS_A = 0
) (
	input wire core_clk,
	input wire srst,
	input wire tick,
	input wire pwm_mode,
	input wire toggle_ok,
	input wire at_bottom,
	input wire count_down,
	input wire [WIDTH-1:0] counter_value,
	input wire [WIDTH-1:0] top_value,
	input wire [WIDTH-1:0] compare_wr_data,
	input wire compare_wr,
	input wire [1:0] output_action_sel,
	input wire pin_direction_bit,
	input wire flag_clr,
	output wire [WIDTH-1:0] compare_value,
	output wire compare_match_flag,
	output wire compare_output,
	output wire pin_out,
	output wire pin_oe
);
	// ==========================================
	// buffer and active compare value
	reg [WIDTH-1:0] buf_ff;
	reg [WIDTH-1:0] act_ff;
	reg flag_ff;
	reg out_ff;
	wire match;
	wire connected;
	wire at_top;
	wire eff_down;
	always @(posedge core_clk) begin
		if (srst) begin
			buf_ff <= `DSPWM_RST_CMP;
			act_ff <= `DSPWM_RST_CMP;
		end else begin
			if (compare_wr) begin
				buf_ff <= compare_wr_data; // [R21]
			end
			// reload only at bottom keeps both slopes equal
			if (tick && pwm_mode && at_bottom) begin
				act_ff <= compare_wr ? compare_wr_data : buf_ff; // [R13] [R21]
			end
		end
	end
	// compare above top never equals the counter, so no match [R12]
	assign match = tick && pwm_mode && (counter_value == act_ff); // [R18]
	// a match at bottom counts as rising and one at top as falling, so a
	// compare at bottom or at top gives a steady level [R16]
	assign at_top = (counter_value == top_value);
	assign eff_down = at_bottom ? 1'b0 : at_top ? 1'b1 : count_down;
	// ==========================================
	// flag: set wins over clear
	always @(posedge core_clk) begin
		if (srst) begin
			flag_ff <= 1'b0;
		end else if (match) begin
			flag_ff <= 1'b1; // [R08]
		end else if (flag_clr) begin
			flag_ff <= 1'b0;
		end
	end
	// ==========================================
	// waveform
	always @(posedge core_clk) begin
		if (srst) begin
			out_ff <= 1'b0;
		end else if (match && pwm_mode) begin
			case (output_action_sel) // [R04]
				`DSPWM_ACT_NONINV: out_ff <= eff_down; // [R02] [R16]
				`DSPWM_ACT_INV: out_ff <= ~eff_down; // [R03] [R16]
				`DSPWM_ACT_TOGGLE: out_ff <= (IS_A != 0 && toggle_ok) ? ~out_ff : out_ff; // [R17] [R20]
				default: out_ff <= out_ff;
			endcase
		end
	end
	assign connected = (output_action_sel == `DSPWM_ACT_NONINV) ||
		(output_action_sel == `DSPWM_ACT_INV) ||
		(output_action_sel == `DSPWM_ACT_TOGGLE && IS_A != 0 && toggle_ok); // [R20]
	assign pin_oe = connected && pin_direction_bit; // [R14]
	assign pin_out = out_ff & pin_oe;
	assign compare_value = act_ff;
	assign compare_match_flag = flag_ff;
	assign compare_output = out_ff;
endmodule // dspwm_channel
`default_nettype wire

// *** rtl/dspwm_top.v ***
/*
 * Dual-slope, phase and frequency correct pwm timer core with two
 * compare channels (a, b), a capture/top register and flags.
 * Assumes timer_tick comes from an outside prescaler in the core_clk
 * domain as a one-cycle enable, and that flag clears are one-cycle pulses.
 */
// Functional notes
// R01 - modes 8 and 9 count up then down
// R02 - noninverting: clear on up, set on down
// R03 - inverting: set on up, clear on down
// R04 - action two noninverted, three inverted
// R05 - top from capture (8) or compare a (9)
// R06 - counter stays at top one tick
// R07 - top from 0x0003 to full 16 bits
// R08 - channel match sets its match flag
// R09 - overflow flag set at bottom reload tick
// R10 - top reach sets a flag or capture flag
// R11 - software keeps top above all compares
// R12 - compare above top never matches
// R13 - compare reload only at bottom
// R14 - pin driven only when direction is output
// R15 - period is two times top times prescale
// R16 - bottom compare low, top compare high
// R17 - mode 9 toggle gives square wave
// R18 - fully synchronous, tick is only enable
// R19 - fixed period uses capture, varying uses a
// R20 - toggle only modes 9/11, else disconnected
// R21 - writes land in buffer until bottom
`timescale 1ns/10ps
`default_nettype none
`include "dspwm_defines.vh"
module dspwm_top #(
	parameter WIDTH = `DSPWM_WIDTH
) (
	input wire core_clk,
	input wire srst,
	input wire timer_tick,
	input wire [3:0] waveform_mode_sel,
	input wire [1:0] output_action_a_sel,
	input wire [1:0] output_action_b_sel,
	input wire [WIDTH-1:0] capture_wr_data,
	input wire capture_wr,
	input wire [WIDTH-1:0] compare_a_wr_data,
	input wire compare_a_wr,
	input wire [WIDTH-1:0] compare_b_wr_data,
	input wire compare_b_wr,
	input wire pin_direction_a_bit,
	input wire pin_direction_b_bit,
	input wire overflow_flag_clr,
	input wire capture_flag_clr,
	input wire compare_a_flag_clr,
	input wire compare_b_flag_clr,
	output wire [WIDTH-1:0] counter_value,
	output wire count_down,
	output wire [WIDTH-1:0] capture_value,
	output wire [WIDTH-1:0] compare_a_value,
	output wire [WIDTH-1:0] compare_b_value,
	output wire overflow_flag,
	output wire capture_flag,
	output wire compare_a_match_flag,
	output wire compare_b_match_flag,
	output wire compare_output_a,
	output wire compare_output_b,
	output wire pin_a_out,
	output wire pin_a_oe,
	output wire pin_b_out,
	output wire pin_b_oe
);
	// ==========================================
	// mode decode
	wire mode_cap;
	wire mode_cmpa;
	wire pwm_mode;
	wire toggle_ok;
	assign mode_cap = (waveform_mode_sel == `DSPWM_MODE_CAPTOP);
	assign mode_cmpa = (waveform_mode_sel == `DSPWM_MODE_CMPATOP);
	assign pwm_mode = mode_cap | mode_cmpa; // [R01]
	assign toggle_ok = mode_cmpa || (waveform_mode_sel == `DSPWM_MODE_PCCMPATOP); // [R20]

	// ==========================================
	// capture register, software written
	reg [WIDTH-1:0] cap_ff;
	always @(posedge core_clk) begin
		if (srst) begin
			cap_ff <= `DSPWM_RST_TOP;
		end else if (capture_wr) begin
			cap_ff <= capture_wr_data;
		end
	end
	assign capture_value = cap_ff;

	// ==========================================
	// top select
	// values below the minimum top are not blocked; software keeps them legal
	wire [WIDTH-1:0] top_value;
	assign top_value = mode_cmpa ? compare_a_value : cap_ff; // [R05] [R07]

	// ==========================================
	// dual-slope counter
	// all state advances on core_clk; timer_tick only enables it [R18]
	reg [WIDTH-1:0] cnt_ff;
	reg down_ff;
	reg [WIDTH-1:0] nxt_cnt;
	reg nxt_down;
	wire at_top;
	wire at_bottom;
	assign at_top = (cnt_ff == top_value);
	assign at_bottom = (cnt_ff == `DSPWM_BOTTOM);
	always @* begin
		nxt_cnt = cnt_ff;
		nxt_down = down_ff;
		if (timer_tick && pwm_mode) begin
			if (!down_ff) begin
				if (at_top) begin
					// direction flips now, so top lasts one tick [R06]
					nxt_down = 1'b1; // [R05]
					nxt_cnt = cnt_ff - 1'b1;
				end else begin
					nxt_cnt = cnt_ff + 1'b1; // [R01]
				end
			end else begin
				if (at_bottom) begin
					nxt_down = 1'b0;
					nxt_cnt = cnt_ff + 1'b1;
				end else begin
					nxt_cnt = cnt_ff - 1'b1; // [R01]
				end
			end
			// one period spans 2*top ticks, so 2*top*n clocks [R15]
		end
	end
	always @(posedge core_clk) begin
		if (srst) begin
			cnt_ff <= `DSPWM_BOTTOM;
			down_ff <= 1'b1;
		end else begin
			cnt_ff <= nxt_cnt;
			down_ff <= nxt_down;
		end
	end
	assign counter_value = cnt_ff;
	assign count_down = down_ff;

	// ==========================================
	// overflow and capture flags, set beats clear
	reg ovf_ff;
	reg capf_ff;
	wire tick_top;
	wire tick_bottom;
	assign tick_top = timer_tick && pwm_mode && at_top;
	assign tick_bottom = timer_tick && pwm_mode && at_bottom;
	always @(posedge core_clk) begin
		if (srst) begin
			ovf_ff <= 1'b0;
			capf_ff <= 1'b0;
		end else begin
			if (tick_bottom) begin
				ovf_ff <= 1'b1; // [R09]
			end else if (overflow_flag_clr) begin
				ovf_ff <= 1'b0;
			end
			if (tick_top && mode_cap) begin
				capf_ff <= 1'b1; // [R10]
			end else if (capture_flag_clr) begin
				capf_ff <= 1'b0;
			end
		end
	end
	assign overflow_flag = ovf_ff;
	assign capture_flag = capf_ff;

	// ==========================================
	// compare channels; in mode 9 channel a matching at top is its top flag [R10]
	dspwm_channel #(
		.WIDTH(WIDTH),
		.IS_A(1)
	) u_ch_a (
		.core_clk(core_clk),
		.srst(srst),
		.tick(timer_tick),
		.pwm_mode(pwm_mode),
		.toggle_ok(toggle_ok),
		.at_bottom(at_bottom),
		.count_down(down_ff),
		.counter_value(cnt_ff),
		.top_value(top_value),
		.compare_wr_data(compare_a_wr_data),
		.compare_wr(compare_a_wr),
		.output_action_sel(output_action_a_sel),
		.pin_direction_bit(pin_direction_a_bit),
		.flag_clr(compare_a_flag_clr),
		.compare_value(compare_a_value),
		.compare_match_flag(compare_a_match_flag),
		.compare_output(compare_output_a),
		.pin_out(pin_a_out),
		.pin_oe(pin_a_oe)
	);
	dspwm_channel #(
		.WIDTH(WIDTH),
		.IS_A(0)
	) u_ch_b (
		.core_clk(core_clk),
		.srst(srst),
		.tick(timer_tick),
		.pwm_mode(pwm_mode),
		.toggle_ok(toggle_ok),
		.at_bottom(at_bottom),
		.count_down(down_ff),
		.counter_value(cnt_ff),
		.top_value(top_value),
		.compare_wr_data(compare_b_wr_data),
		.compare_wr(compare_b_wr),
		.output_action_sel(output_action_b_sel),
		.pin_direction_bit(pin_direction_b_bit),
		.flag_clr(compare_b_flag_clr),
		.compare_value(compare_b_value),
		.compare_match_flag(compare_b_match_flag),
		.compare_output(compare_output_b),
		.pin_out(pin_b_out),
		.pin_oe(pin_b_oe)
	);
endmodule // dspwm_top
`default_nettype wire

// *** testbench/dspwm_load.sv ***
/* load on one pwm pin. assumes pin_out/pin_oe come from the timer core. */
`timescale 1ns/10ps
`default_nettype none
module dspwm_load (
	input wire core_clk,
	input wire pin_out,
	input wire pin_oe,
	output logic pad
);
	// ==========
	// pad level
	logic last_ff;
	always @(posedge core_clk) if (pin_oe) last_ff <= pin_out;
	// released pad shows the inverse, so a stale level never passes
	assign pad = pin_oe ? pin_out : ~last_ff;
endmodule // dspwm_load
`default_nettype wire

// *** testbench/dspwm_properties.sv ***
/* checker of the timer core ports. assumes 16-bit counter and one clock. */
`timescale 1ns/10ps
`default_nettype none
module dspwm_props #(parameter WIDTH = 16) (
	input wire core_clk,
	input wire srst,
	input wire timer_tick,
	input wire [3:0] waveform_mode_sel,
	input wire [1:0] output_action_a_sel,
	input wire [1:0] output_action_b_sel,
	input wire pin_direction_b_bit,
	input wire [WIDTH-1:0] counter_value,
	input wire count_down,
	input wire [WIDTH-1:0] capture_value,
	input wire [WIDTH-1:0] compare_a_value,
	input wire [WIDTH-1:0] compare_b_value,
	input wire overflow_flag,
	input wire capture_flag,
	input wire compare_b_match_flag,
	input wire compare_output_a,
	input wire compare_output_b,
	input wire pin_b_out,
	input wire pin_b_oe
);
	// ==========
	// helpers
	wire m8 = waveform_mode_sel == 4'h8;
	wire run = timer_tick && (m8 || waveform_mode_sel == 4'h9);
	wire [WIDTH-1:0] top = m8 ? capture_value : compare_a_value;
	wire bot = run && count_down && counter_value == 16'h0000;
	wire at_top = run && !count_down && counter_value == top;
	wire mb = run && counter_value == compare_b_value;
	// bottom match acts as rising, top match as falling
	wire edn = counter_value == 16'h0000 ? 1'b0 : counter_value == top ? 1'b1 : count_down;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	// ==========
	// properties
	property p_up; run && !count_down && !at_top |=> counter_value == $past(counter_value) + 16'h0001; endproperty
	a_up: assert property (p_up) else $error("up step wrong");
	property p_dn; run && count_down && !bot |=> counter_value == $past(counter_value) - 16'h0001; endproperty
	a_dn: assert property (p_dn) else $error("down step wrong");
	property p_top; at_top |=> count_down && counter_value == $past(counter_value) - 16'h0001; endproperty
	a_top: assert property (p_top) else $error("turn at top wrong");
	property p_cap; at_top && m8 |=> capture_flag; endproperty
	a_cap: assert property (p_cap) else $error("top flag missing");
	property p_bot; bot |=> overflow_flag && !count_down && counter_value == 16'h0001; endproperty
	a_bot: assert property (p_bot) else $error("bottom turn wrong");
	property p_hold; !bot |=> $stable(compare_b_value); endproperty
	a_hold: assert property (p_hold) else $error("compare changed off bottom");
	property p_nb; mb && output_action_b_sel == 2'h2 |=> compare_output_b == $past(edn) && compare_b_match_flag; endproperty
	a_nb: assert property (p_nb) else $error("noninverting match wrong");
	property p_ib; mb && output_action_b_sel == 2'h3 |=> compare_output_b == !$past(edn); endproperty
	a_ib: assert property (p_ib) else $error("inverting match wrong");
	property p_tg; run && !m8 && output_action_a_sel == 2'h1 && counter_value == compare_a_value |=> compare_output_a != $past(compare_output_a); endproperty
	a_tg: assert property (p_tg) else $error("toggle missing");
	property p_pin; !pin_direction_b_bit |-> !pin_b_oe && !pin_b_out; endproperty
	a_pin: assert property (p_pin) else $error("pin driven as input");
	property p_off; output_action_b_sel == 2'h1 |-> !pin_b_oe; endproperty
	a_off: assert property (p_off) else $error("toggle on b connected");
endmodule // dspwm_props
bind dspwm_top dspwm_props #(.WIDTH(WIDTH)) i_dspwm_props (.core_clk, .srst, .timer_tick, .waveform_mode_sel,
	.output_action_a_sel, .output_action_b_sel, .pin_direction_b_bit, .counter_value, .count_down,
	.capture_value, .compare_a_value, .compare_b_value, .overflow_flag, .capture_flag,
	.compare_b_match_flag, .compare_output_a, .compare_output_b, .pin_b_out, .pin_b_oe);
`default_nettype wire

// *** testbench/tb_dual_slope_freq_correct_pwm.sv ***
/* bench for the timer core with a reference model. assumes one 10 MHz clock. */
`timescale 1ns/10ps
`default_nettype none
module tb_dual_slope_freq_correct_pwm;
	logic core_clk, srst, timer_tick, capture_wr, compare_a_wr, compare_b_wr;
	logic pin_direction_a_bit, pin_direction_b_bit;
	logic overflow_flag_clr, capture_flag_clr, compare_a_flag_clr, compare_b_flag_clr;
	logic [3:0] waveform_mode_sel;
	logic [1:0] output_action_a_sel, output_action_b_sel;
	logic [15:0] capture_wr_data, compare_a_wr_data, compare_b_wr_data, top, t;
	wire [15:0] counter_value, capture_value, compare_a_value, compare_b_value;
	wire count_down, overflow_flag, capture_flag, compare_a_match_flag, compare_b_match_flag;
	wire compare_output_a, compare_output_b, pin_a_out, pin_a_oe, pin_b_out, pin_b_oe, pad_a, pad_b;
	logic [15:0] m_cnt, m_cap, m_ca, m_cb, m_ba, m_bb;
	logic m_dn, m_ed, m_ovf, m_icf, m_fa, m_fb, m_oa, m_ob, run, ld;
	logic [31:0] r;
	int seed = 32'h93e4;
	int err_total = 0;
	int cmp_count = 0;
	int k;
	dspwm_top i_dspwm_top (.*);
	dspwm_load i_dspwm_load_a (.core_clk(core_clk), .pin_out(pin_a_out), .pin_oe(pin_a_oe), .pad(pad_a));
	dspwm_load i_dspwm_load_b (.core_clk(core_clk), .pin_out(pin_b_out), .pin_oe(pin_b_oe), .pad(pad_b));
	wire ea = pin_direction_a_bit && (output_action_a_sel > 2'h1 || output_action_a_sel == 2'h1
		&& (waveform_mode_sel == 4'h9 || waveform_mode_sel == 4'hb));
	wire eb = pin_direction_b_bit && output_action_b_sel > 2'h1;
	always #50 core_clk = ~core_clk;
	task chk(input string nm, input logic [79:0] s, input logic [79:0] e);
		cmp_count++;
		if (s !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	task end_of_test;
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// toggle only where allowed; bottom match acts as rising, top match as falling
	function logic act(input logic [1:0] s, input logic o, input logic tg);
		act = s == 2'h1 ? o ^ tg : s == 2'h2 ? m_ed : s == 2'h3 ? !m_ed : o;
	endfunction
	// ==========
	// reference model, updated on the same edge as the core
	always @(posedge core_clk) begin
		if (srst) begin
			{m_cnt, m_ca, m_cb, m_ba, m_bb} = 0;
			{m_ovf, m_icf, m_fa, m_fb, m_oa, m_ob} = 0;
			m_cap = 16'hffff;
			m_dn = 1'b1;
		end else begin
			run = timer_tick && (waveform_mode_sel == 4'h8 || waveform_mode_sel == 4'h9);
			top = waveform_mode_sel == 4'h8 ? m_cap : m_ca;
			ld = run && m_dn && m_cnt == 16'h0000;
			{m_ovf, m_icf} = {m_ovf & !overflow_flag_clr, m_icf & !capture_flag_clr};
			{m_fa, m_fb} = {m_fa & !compare_a_flag_clr, m_fb & !compare_b_flag_clr};
			// matches see the count before it steps
			m_ed = m_cnt == 16'h0000 ? 1'b0 : m_cnt == top ? 1'b1 : m_dn;
			if (run && m_cnt == m_ca)
				{m_fa, m_oa} = {1'b1, act(output_action_a_sel, m_oa, waveform_mode_sel == 4'h9)};
			if (run && m_cnt == m_cb) {m_fb, m_ob} = {1'b1, act(output_action_b_sel, m_ob, 1'b0)};
			if (ld) {m_ovf, m_dn, m_cnt} = {2'b10, 16'h0001};
			else if (run && !m_dn && m_cnt == top) begin
				m_icf |= waveform_mode_sel == 4'h8;
				{m_dn, m_cnt} = {1'b1, m_cnt - 16'h0001};
			end else if (run) m_cnt = m_dn ? m_cnt - 16'h0001 : m_cnt + 16'h0001;
			if (capture_wr) m_cap = capture_wr_data;
			if (compare_a_wr) m_ba = compare_a_wr_data;
			if (compare_b_wr) m_bb = compare_b_wr_data;
			if (ld) {m_ca, m_cb} = {m_ba, m_bb};
		end
	end
	always @(negedge core_clk) if (!srst) begin
		chk("count", {counter_value, count_down}, {m_cnt, m_dn});
		chk("values", {capture_value, compare_a_value, compare_b_value}, {m_cap, m_ca, m_cb});
		chk("flags", {overflow_flag, capture_flag, compare_a_match_flag, compare_b_match_flag},
			{m_ovf, m_icf, m_fa, m_fb});
		chk("out_a", compare_output_a, m_oa);
		chk("out_b", compare_output_b, m_ob);
		chk("oe", {pin_a_oe, pin_b_oe}, {ea, eb});
		chk("pins", {pin_a_out, pin_b_out, pad_a & ea, pad_b & eb},
			{m_oa & ea, m_ob & eb, m_oa & ea, m_ob & eb});
	end
	// ==========
	// stimulus: a fresh reset for each mode and action setting
	initial begin
		core_clk = 1'b0;
		srst = 1'b1;
		{timer_tick, capture_wr, compare_a_wr, compare_b_wr, pin_direction_a_bit, pin_direction_b_bit} = 0;
		{overflow_flag_clr, capture_flag_clr, compare_a_flag_clr, compare_b_flag_clr} = 0;
		{waveform_mode_sel, output_action_a_sel, output_action_b_sel} = 0;
		{capture_wr_data, compare_a_wr_data, compare_b_wr_data} = 0;
		for (k = 0; k < 8; k++) begin
			@(posedge core_clk);
			{srst, timer_tick, capture_wr, compare_a_wr, compare_b_wr} <= 5'h10;
			repeat (10) @(posedge core_clk);
			r = $random(seed);
			t = 16'h000c + r[2:0];
			srst <= 1'b0;
			waveform_mode_sel <= k == 7 ? 4'hb : k % 2 ? 4'h9 : 4'h8;
			output_action_a_sel <= (k % 2 || k > 5) ? 2'h1 : (k & 2) ? 2'h3 : 2'h2;
			output_action_b_sel <= k == 7 ? 2'h0 : k > 5 ? 2'h1 : (k & 2) ? 2'h3 : 2'h2;
			{capture_wr, compare_a_wr, compare_b_wr} <= 3'h7;
			capture_wr_data <= t;
			compare_a_wr_data <= k % 2 ? t : {13'h0, r[5:3]};
			// compare above top never matches; compare at top and at bottom are edge cases
			compare_b_wr_data <= k == 5 ? 16'h0030 : k == 4 ? t : k == 0 ? 16'h0000 : {13'h0, r[8:6]};
			repeat (400) begin
				@(posedge core_clk);
				r = $random(seed);
				{timer_tick, pin_direction_a_bit, pin_direction_b_bit} <= r[2:0];
				{overflow_flag_clr, capture_flag_clr} <= {r[5:3] == 3'h0, r[8:6] == 3'h0};
				{compare_a_flag_clr, compare_b_flag_clr} <= {r[11:9] == 3'h0, r[14:12] == 3'h0};
				capture_wr <= 1'b0;
				// buffer writes mid-period; new tops stay above every compare
				compare_b_wr <= k > 0 && k < 4 && r[20:17] == 4'h0 && r[15];
				compare_a_wr <= k % 2 && k < 4 && r[20:17] == 4'h0 && r[16];
				compare_b_wr_data <= {13'h0, r[23:21]};
				compare_a_wr_data <= 16'h000c + r[27:25];
			end
		end
		end_of_test;
	end
endmodule // tb_dual_slope_freq_correct_pwm
`default_nettype wire
